// >>> hdl/axil_reg_slave.sv
// AXI4-Lite slave front end: turns bus transfers into one-cycle register strobes.
// Assumes one clock; the owner answers reads combinationally from rd_addr.
module axil_reg_slave (
    input wire logic clk,
    input wire logic reset,
    input wire logic [seq_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [seq_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_stb,
    output logic [seq_pkg::ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    output logic rd_stb,
    output logic [seq_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data
);
    import seq_pkg::*;

    logic bvalid_r; // Write response pending
    logic rvalid_r; // Read data pending
    logic [31:0] rdata_r; // Captured read word

    // Address and data are taken together, only when no response is pending
    assign wr_stb = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign s_axi_awready = wr_stb;
    assign s_axi_wready = wr_stb;
    assign wr_addr = s_axi_awaddr;
    assign wr_data = s_axi_wdata;
    assign wr_strb = s_axi_wstrb;

    // Read address taken while no read data is pending
    assign rd_stb = s_axi_arvalid && !rvalid_r;
    assign s_axi_arready = rd_stb;
    assign rd_addr = s_axi_araddr;

    // Every access, mapped or not, answers OKAY
    assign s_axi_bresp = 2'h0;
    assign s_axi_rresp = 2'h0;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;

    // Write response one cycle after the take, held until bready
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bvalid_r <= 1'b0;
        end else if (wr_stb) begin
            bvalid_r <= 1'b1;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read data captured at the take, held until rready
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else if (rd_stb) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_data;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule : axil_reg_slave

// >>> hdl/scan_sequencer.sv
// Trigger-driven relay scan sequencer with AXI4-Lite control registers.
// Assumes ext_trig is a synchronous one-cycle pulse; relays follow the relay_* outputs.
// Function
// [R1]: Reset puts sequencer in idle.
// [R2]: Continuous arm with defined list arms.
// [R3]: Trigger opens current channel, closes next.
// [R4]: Continuous run wraps forever until stop.
// [R5]: Stop idles and opens closed relay.
// [R6]: Hold source ignores all trigger sources.
// [R7]: Immediate-trigger command steps even under hold.
// [R8]: First trigger only closes first channel.
// [R9]: Immediate source free-runs until stop.
// [R10]: Pass count sets single-run traversals.
// [R11]: Single run idles after programmed passes.
// [R12]: Idle ignores triggers, relays unchanged.
// [R13]: Immediate-trigger command acts at once.
// [R14]: Continuous arm without list stays idle.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
module scan_sequencer #(
    parameter int LIST_DEPTH = seq_pkg::LIST_DEPTH_DEF,
    parameter int CHAN_W = seq_pkg::CHAN_W_DEF
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [seq_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [seq_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_trig,
    output logic [CHAN_W-1:0] relay_chan,
    output logic relay_on,
    output logic relay_open_stb,
    output logic relay_close_stb
);
    import seq_pkg::*;

    localparam int IDX_W = (LIST_DEPTH > 1) ? $clog2(LIST_DEPTH) : 1;
    localparam int LEN_W = $clog2(LIST_DEPTH + 1);

    // Merge a written word into an old one by byte enables
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // True when an address falls on a scan list entry
    function automatic logic list_hit(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] ofs;
        ofs = addr - OFS_LIST_BASE;
        return (addr >= OFS_LIST_BASE) && (ofs[1:0] == 2'h0) &&
               ({2'h0, ofs[ADDR_W-1:2]} < ADDR_W'(LIST_DEPTH));
    endfunction : list_hit

    // Entry index of a scan list address
    function automatic logic [IDX_W-1:0] list_sel(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] ofs;
        ofs = (addr - OFS_LIST_BASE) >> 2;
        return ofs[IDX_W-1:0];
    endfunction : list_sel

    // Register strobes from the bus front end
    logic wr_stb;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic rd_stb;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;

    // Configuration registers
    trig_src_t source_r;
    logic [COUNT_W-1:0] count_r;
    logic [LEN_W-1:0] list_len_r;
    logic [CHAN_W-1:0] list_mem [LIST_DEPTH];

    // Sequencer state and its next values
    seq_state_t state_r, state_nxt;
    logic [IDX_W-1:0] idx_r, idx_nxt;
    logic single_r, single_nxt;
    logic [COUNT_W-1:0] pass_r, pass_nxt;
    logic [CHAN_W-1:0] chan_r, chan_nxt;
    logic on_r, on_nxt;
    logic open_r, open_nxt;
    logic close_r, close_nxt;

    axil_reg_slave u_bus (
        .clk(clk),
        .reset(reset),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .rd_stb(rd_stb),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // Command decode; commands live in the low byte of the control word
    wire ctrl_wr = wr_stb && (wr_addr == OFS_CTRL) && wr_strb[0];
    wire arm_cont_cmd = ctrl_wr && wr_data[CTRL_ARM_CONT_BIT];
    wire arm_single_cmd = ctrl_wr && wr_data[CTRL_ARM_SINGLE_BIT];
    wire abort_cmd = ctrl_wr && wr_data[CTRL_ABORT_BIT];
    wire imm_trig_cmd = ctrl_wr && wr_data[CTRL_IMM_TRIG_BIT];
    wire bus_trig_cmd = wr_stb && (wr_addr == OFS_BUS_TRIG);
    wire is_idle = (state_r == S_IDLE);
    wire list_defined = (list_len_r != '0);

    // Source gating: hold passes nothing, immediate fires every armed cycle
    wire src_fire = (source_r == SRC_IMM) ||                  // [R9]
                    ((source_r == SRC_EXT) && ext_trig) ||
                    ((source_r == SRC_BUS) && bus_trig_cmd);  // [R6]
    wire trig_fire = imm_trig_cmd || src_fire;                // [R7] [R13]

    // Position in the list and end-of-run detection
    wire at_last = ({{(32-IDX_W){1'b0}}, idx_r} == 32'(list_len_r) - 32'd1);
    wire last_done = at_last && single_r && (pass_r == 16'h0001);  // [R11]
    wire [IDX_W-1:0] idx_wrap = at_last ? '0 : IDX_W'(idx_r + 1'b1); // [R4]

    // Configuration writes; list and length only change while idle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            source_r <= RST_SOURCE;
            count_r <= RST_COUNT;
            list_len_r <= '0;
        end else if (wr_stb) begin
            if (wr_addr == OFS_SOURCE && wr_strb[0]) begin
                source_r <= trig_src_t'(wr_data[1:0]);
            end
            if (wr_addr == OFS_COUNT) begin
                count_r <= COUNT_W'(merge_bytes({16'h0000, count_r}, wr_data,
                                                wr_strb));    // [R10]
            end
            if (wr_addr == OFS_LIST_LEN && wr_strb[0] && is_idle &&
                wr_data[7:0] <= 8'(LIST_DEPTH)) begin
                list_len_r <= LEN_W'(wr_data[7:0]);
            end
        end
    end

    // Scan list entries, flip-flop storage indexed by entry
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < LIST_DEPTH; i++) begin
                list_mem[i] <= '0;
            end
        end else if (wr_stb && is_idle && list_hit(wr_addr)) begin
            list_mem[list_sel(wr_addr)] <= CHAN_W'(merge_bytes(
                32'(list_mem[list_sel(wr_addr)]), wr_data, wr_strb));
        end
    end

    // Read multiplexer; unmapped addresses read as zero
    always_comb begin
        rd_data = 32'h0000_0000;
        if (rd_addr == OFS_SOURCE) begin
            rd_data[1:0] = source_r;
        end else if (rd_addr == OFS_COUNT) begin
            rd_data[COUNT_W-1:0] = count_r;
        end else if (rd_addr == OFS_LIST_LEN) begin
            rd_data[LEN_W-1:0] = list_len_r;
        end else if (rd_addr == OFS_STATUS) begin
            rd_data[STAT_ARMED_BIT] = !is_idle;
            rd_data[STAT_RELAY_ON_BIT] = on_r;
            rd_data[STAT_SINGLE_BIT] = single_r;
            rd_data[STAT_CHAN_LSB +: CHAN_W] = chan_r;
            rd_data[STAT_PASS_LSB +: COUNT_W] = pass_r;
        end else if (list_hit(rd_addr)) begin
            rd_data[CHAN_W-1:0] = list_mem[list_sel(rd_addr)];
        end
    end

    // Sequencer next-state logic
    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        single_nxt = single_r;
        pass_nxt = pass_r;
        chan_nxt = chan_r;
        on_nxt = on_r;
        open_nxt = 1'b0;
        close_nxt = 1'b0;
        case (state_r)
            S_IDLE: begin
                // Triggers are not looked at here [R12]
                if (arm_cont_cmd && list_defined) begin                      // [R2] [R14]
                    state_nxt = S_ARMED;
                    idx_nxt = '0;
                    single_nxt = 1'b0;
                end else if (arm_single_cmd && list_defined && count_r != '0) begin
                    state_nxt = S_ARMED;                                     // [R10]
                    idx_nxt = '0;
                    single_nxt = 1'b1;
                    pass_nxt = count_r;
                end
            end
            S_ARMED: begin
                if (abort_cmd) begin
                    // Stop wins over a trigger in the same cycle
                    state_nxt = S_IDLE;                                      // [R5]
                    if (on_r) begin
                        on_nxt = 1'b0;
                        open_nxt = 1'b1;
                    end
                end else if (trig_fire && !on_r) begin
                    // Nothing closed yet: close the current entry only
                    on_nxt = 1'b1;                                           // [R8]
                    close_nxt = 1'b1;
                    chan_nxt = list_mem[idx_r];
                end else if (trig_fire) begin
                    // Open the closed channel first, close the next one after
                    on_nxt = 1'b0;                                           // [R3]
                    open_nxt = 1'b1;
                    if (last_done) begin
                        state_nxt = S_IDLE;                                  // [R11]
                    end else begin
                        state_nxt = S_CLOSE;
                        idx_nxt = idx_wrap;                                  // [R4]
                        if (at_last && single_r) begin
                            pass_nxt = pass_r - 16'h0001;
                        end
                    end
                end
            end
            S_CLOSE: begin
                if (abort_cmd) begin
                    // Relay is already open during this step
                    state_nxt = S_IDLE;                                      // [R5]
                end else begin
                    state_nxt = S_ARMED;                                     // [R3]
                    on_nxt = 1'b1;
                    close_nxt = 1'b1;
                    chan_nxt = list_mem[idx_r];
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= S_IDLE;                                               // [R1]
            idx_r <= '0;
            single_r <= 1'b0;
            pass_r <= '0;
            chan_r <= '0;
            on_r <= 1'b0;
            open_r <= 1'b0;
            close_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            single_r <= single_nxt;
            pass_r <= pass_nxt;
            chan_r <= chan_nxt;
            on_r <= on_nxt;
            open_r <= open_nxt;
            close_r <= close_nxt;
        end
    end

    // Relay drive outputs
    assign relay_chan = chan_r;
    assign relay_on = on_r;
    assign relay_open_stb = open_r;
    assign relay_close_stb = close_r;

    // Checks
    property p_reset_idle;
        @(posedge clk) $fell(reset) |-> (state_r == S_IDLE) && !on_r;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset"); // [R1]

    property p_arm_cont;
        @(posedge clk) disable iff (reset)
        is_idle && arm_cont_cmd && list_defined |=> state_r == S_ARMED && !single_r;
    endproperty
    a_arm_cont: assert property (p_arm_cont) else $error("continuous arm failed"); // [R2]

    property p_no_list;
        @(posedge clk) disable iff (reset)
        is_idle && !list_defined && (arm_cont_cmd || arm_single_cmd)
            |=> is_idle && $stable(on_r) && !close_r && !open_r;
    endproperty
    a_no_list: assert property (p_no_list) else $error("armed without list"); // [R14]

    property p_step_order;
        @(posedge clk) disable iff (reset)
        state_r == S_ARMED && trig_fire && on_r && !abort_cmd && !last_done
            |=> open_r && !close_r ##1 ($past(abort_cmd) ? is_idle :
                (close_r && on_r && chan_r == list_mem[idx_r]));
    endproperty
    a_step_order: assert property (p_step_order) else $error("step not open then close"); // [R3]

    property p_wrap;
        @(posedge clk) disable iff (reset)
        state_r == S_ARMED && trig_fire && on_r && at_last && !single_r && !abort_cmd
            |=> state_r == S_CLOSE && idx_r == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("continuous run did not wrap"); // [R4]

    property p_abort;
        @(posedge clk) disable iff (reset)
        !is_idle && abort_cmd |=> is_idle && !on_r && (open_r == $past(on_r));
    endproperty
    a_abort: assert property (p_abort) else $error("stop did not idle and open"); // [R5]

    property p_hold;
        @(posedge clk) disable iff (reset)
        state_r == S_ARMED && source_r == SRC_HOLD && !imm_trig_cmd
            |=> !open_r && !close_r;
    endproperty
    a_hold: assert property (p_hold) else $error("step under hold"); // [R6]

    property p_imm_cmd;
        @(posedge clk) disable iff (reset)
        state_r == S_ARMED && imm_trig_cmd && !abort_cmd |=> open_r || close_r;
    endproperty
    a_imm_cmd: assert property (p_imm_cmd) else $error("immediate command did not step"); // [R7]

    property p_first;
        @(posedge clk) disable iff (reset)
        state_r == S_ARMED && trig_fire && !on_r && !abort_cmd
            |=> close_r && !open_r && chan_r == list_mem[$past(idx_r)];
    endproperty
    a_first: assert property (p_first) else $error("first trigger wrong"); // [R8]

    property p_imm_src;
        @(posedge clk) disable iff (reset)
        state_r == S_ARMED && source_r == SRC_IMM && !abort_cmd |=> open_r || close_r;
    endproperty
    a_imm_src: assert property (p_imm_src) else $error("immediate source stalled"); // [R9]

    property p_pass_load;
        @(posedge clk) disable iff (reset)
        is_idle && arm_single_cmd && !arm_cont_cmd && list_defined && count_r != '0
            |=> single_r && pass_r == $past(count_r);
    endproperty
    a_pass_load: assert property (p_pass_load) else $error("pass count not loaded"); // [R10]

    property p_single_end;
        @(posedge clk) disable iff (reset)
        state_r == S_ARMED && trig_fire && on_r && last_done && !abort_cmd
            |=> is_idle && open_r && !on_r;
    endproperty
    a_single_end: assert property (p_single_end) else $error("single run did not end"); // [R11]

    property p_idle_quiet;
        @(posedge clk) disable iff (reset)
        is_idle |=> !close_r && $stable(chan_r);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("relay moved while idle"); // [R12]

    c_single_done: cover property (@(posedge clk) disable iff (reset)
        state_r == S_ARMED ##1 is_idle && open_r && !$past(abort_cmd));
    c_abort_on: cover property (@(posedge clk) disable iff (reset) abort_cmd && on_r);
    c_wrap: cover property (@(posedge clk) disable iff (reset)
        state_r == S_CLOSE && idx_r == '0 && !single_r);

endmodule : scan_sequencer

// >>> hdl/seq_pkg.sv
// Package for the relay scan trigger sequencer: register map, fields, resets, states.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses in the low ADDR_W bits.
package seq_pkg;

    // Byte address width seen by the register slave
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SOURCE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LIST_LEN = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_BUS_TRIG = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_LIST_BASE = 8'h40;

    // Command bits of the write-only control register
    localparam int CTRL_ARM_CONT_BIT = 0;
    localparam int CTRL_ARM_SINGLE_BIT = 1;
    localparam int CTRL_ABORT_BIT = 2;
    localparam int CTRL_IMM_TRIG_BIT = 3;

    // Status register field positions
    localparam int STAT_ARMED_BIT = 0;
    localparam int STAT_RELAY_ON_BIT = 1;
    localparam int STAT_SINGLE_BIT = 2;
    localparam int STAT_CHAN_LSB = 8;
    localparam int STAT_PASS_LSB = 16;

    // Default sizes
    localparam int LIST_DEPTH_DEF = 16;
    localparam int CHAN_W_DEF = 8;
    localparam int COUNT_W = 16;

    // Trigger source selection
    typedef enum logic [1:0] {
        SRC_HOLD = 2'h0,
        SRC_EXT = 2'h1,
        SRC_BUS = 2'h2,
        SRC_IMM = 2'h3
    } trig_src_t;

    // Reset values
    localparam trig_src_t RST_SOURCE = SRC_HOLD;
    localparam logic [COUNT_W-1:0] RST_COUNT = 16'h0001;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_ARMED = 3'b010,
        S_CLOSE = 3'b100
    } seq_state_t;

endpackage : seq_pkg

// >>> sim/relay_bank.sv
// Relay bank stand-in: counts the open and close strobes of the sequencer.
// Assumes the sequencer's clock; strobes are one-cycle pulses.
module relay_bank (
    input wire logic clk,
    input wire logic reset,
    input wire logic open_stb,
    input wire logic close_stb,
    output int opens,
    output int closes
);
    timeunit 1ns;
    timeprecision 1ps;

    // Tally relay operations as the coils would see them
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            opens <= 0;
            closes <= 0;
        end else begin
            // One strobe is one relay operation
            if (open_stb === 1'b1) opens <= opens + 1;
            if (close_stb === 1'b1) closes <= closes + 1;
        end
    end
endmodule : relay_bank

// >>> sim/relay_scan_trigger_sequencer_test.sv
// Self-checking bench: drives the sequencer through its register bus.
// Assumes relay_bank follows the relay strobes; one 125 MHz clock.
module relay_scan_trigger_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import seq_pkg::*;
    logic clk = 0;
    logic reset = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, st;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, ext_trig = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic relay_on, relay_open_stb, relay_close_stb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] relay_chan;
    logic [7:0] lst [3] = '{8'h05, 8'h09, 8'h02};
    int opens, closes, snap;
    int fails = 0;
    int comparisons = 0;

    // Free-running clock, 8 ns period
    always #4 clk = ~clk;

    scan_sequencer dut_u (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_trig,
        .relay_chan, .relay_on, .relay_open_stb, .relay_close_stb);

    relay_bank bank_u (.clk, .reset, .open_stb(relay_open_stb),
        .close_stb(relay_close_stb), .opens, .closes);

    // Compare and report
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    // Register write: address and data offered together until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr

    // Register read, held until the answer is sampled
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask : rd

    // Let the relay strobes land, then compare channel, relay and armed flag
    task automatic stat(input string n, input logic arm, input logic [7:0] ch, input logic on);
        repeat (6) @(posedge clk);
        rd(OFS_STATUS, st);
        chk(n, {st[STAT_CHAN_LSB+:8], st[STAT_RELAY_ON_BIT], st[STAT_ARMED_BIT]}, {ch, on, arm});
        chk({n, " pins"}, {relay_chan, relay_on}, {ch, on});
    endtask : stat

    // One cycle of external trigger
    task automatic pulse();
        @(posedge clk);
        ext_trig <= 1'b1;
        @(posedge clk);
        ext_trig <= 1'b0;
    endtask : pulse

    // Verdict and end of run
    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    // Cut a hang short
    initial begin
        #100000;
        fails++;
        conclude();
    end

    // Test sequence
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        stat("reset", 0, 8'h00, 0);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_CTRL, 32'h8);
        stat("no list", 0, 8'h00, 0);
        chk("idle closes", closes, 0);
        $display("test reset done");
        wr(OFS_LIST_LEN, 32'h3);
        for (int i = 0; i < 3; i++) wr(OFS_LIST_BASE + 8'(4 * i), {24'h0, lst[i]});
        wr(OFS_CTRL, 32'h1);
        stat("armed", 1, 8'h00, 0);
        pulse();
        wr(OFS_BUS_TRIG, 32'h1);
        stat("hold", 1, 8'h00, 0);
        wr(OFS_CTRL, 32'h8);
        stat("first", 1, lst[0], 1);
        chk("first open", opens, 0);
        for (int i = 1; i < 5; i++) begin
            wr(OFS_CTRL, 32'h8);
            stat("step", 1, lst[i % 3], 1);
        end
        chk("opens", opens, 4);
        wr(OFS_SOURCE, 32'(SRC_EXT));
        pulse();
        stat("ext", 1, lst[2], 1);
        wr(OFS_SOURCE, 32'(SRC_BUS));
        wr(OFS_BUS_TRIG, 32'h1);
        stat("bus", 1, lst[0], 1);
        snap = opens;
        wr(OFS_CTRL, 32'h4);
        stat("abort", 0, lst[0], 0);
        chk("abort open", opens, snap + 1);
        wr(OFS_BUS_TRIG, 32'h1);
        stat("idle", 0, lst[0], 0);
        $display("test continuous done");
        wr(OFS_SOURCE, 32'(SRC_IMM));
        wr(OFS_CTRL, 32'h1);
        repeat (10) @(posedge clk);
        snap = closes;
        repeat (20) @(posedge clk);
        chk("free run", closes - snap, 10);
        wr(OFS_CTRL, 32'h4);
        repeat (4) @(posedge clk);
        snap = closes;
        repeat (10) @(posedge clk);
        chk("stopped", closes, snap);
        chk("relay off", relay_on, 0);
        $display("test immediate done");
        wr(OFS_SOURCE, 32'(SRC_HOLD));
        wr(OFS_COUNT, 32'h2);
        wr(OFS_CTRL, 32'h2);
        snap = closes;
        repeat (6) wr(OFS_CTRL, 32'h8);
        stat("single run", 1, lst[2], 1);
        wr(OFS_CTRL, 32'h8);
        stat("single end", 0, lst[2], 0);
        chk("single closes", closes - snap, 6);
        $display("test single done");
        conclude();
    end
endmodule : relay_scan_trigger_sequencer_test
